// >>> lbus_bridge.v
// Posting bridge and memory target on a multiplexed 32-bit local bus.
//
// Notes on behaviour
// - never fold repeated writes to one place
// - combine sequential dwords, merge disjoint bytes
// - address phase: address and command driven
// - byte-enable drivers on through transaction end
// - byte enables valid whole phase
// - next byte enables right after completion
// - read: master releases data, one turnaround
// - target drives data after turnaround, stays on
// - word moves when both ready sampled
// - target ready only after select asserted (writes: both asserted on one edge)
// - either not ready means wait cycle
// - frame released only with initiator ready
// - not ready yet keeps frame asserted
// - write: no turnaround, same handshake
// - master never delays byte enables
// - master brings every transaction to end
// - idle when frame and ready both off
// - combined bursts keep original dword order
// - merge only prefetchable, each byte once
// - never combine or merge I/O
`timescale 1ns/1ps
`include "lbus_map.vh"

module lbus_bridge #(
   parameter TGT_AW = 4,
   parameter [31:0] TGT_BASE = 32'h0001_0000,
   parameter BUF_AW = 1
) (
   input wire clk,
   input wire rst_n,
   input wire req_valid,
   output wire req_ready,
   input wire req_read,
   input wire req_io,
   input wire req_prefetch,
   input wire [29:0] req_addr,
   input wire [3:0] req_be,
   input wire [31:0] req_data,
   output reg rsp_valid,
   output reg [31:0] rsp_data,
   input wire frame_n_in,
   output reg frame_n_out,
   output reg frame_n_oe,
   input wire irdy_n_in,
   output reg irdy_n_out,
   output reg irdy_n_oe,
   input wire trdy_n_in,
   output reg trdy_n_out,
   output reg trdy_n_oe,
   input wire devsel_n_in,
   output reg devsel_n_out,
   output reg devsel_n_oe,
   input wire [31:0] ad_in,
   output wire [31:0] ad_out,
   output wire ad_oe,
   input wire [3:0] cbe_n_in,
   output reg [3:0] cbe_n_out,
   output reg cbe_n_oe
);

   localparam [BUF_AW:0] DEPTH = {1'b1, {BUF_AW{1'b0}}};
   localparam [2:0] M_IDLE = 3'd0;
   localparam [2:0] M_LOAD = 3'd1;
   localparam [2:0] M_ADDR = 3'd2;
   localparam [2:0] M_DATA = 3'd3;
   localparam [2:0] M_END = 3'd4;
   localparam [1:0] T_IDLE = 2'd0;
   localparam [1:0] T_TURN = 2'd1;
   localparam [1:0] T_DATA = 2'd2;
   localparam [1:0] T_END = 2'd3;

   // ***************************************************************
   // Request helpers
   // ***************************************************************
   // Next request continues the burst at the following dword.
   function can_combine;
      input [`REQ_W-1:0] a;
      input [`REQ_W-1:0] b;
      begin
         can_combine = !a[`REQ_RD_BIT] && !b[`REQ_RD_BIT] && !a[`REQ_IO_BIT] &&
            !b[`REQ_IO_BIT] &&
            (b[`REQ_ADDR_LSB +: 30] == a[`REQ_ADDR_LSB +: 30] + 30'h1);
      end
   endfunction

   // Next request may share the pending data phase.
   function can_merge;
      input [`REQ_W-1:0] a;
      input [`REQ_W-1:0] b;
      begin
         can_merge = !a[`REQ_RD_BIT] && !b[`REQ_RD_BIT] && !a[`REQ_IO_BIT] &&
            !b[`REQ_IO_BIT] && a[`REQ_PF_BIT] && b[`REQ_PF_BIT] &&
            (b[`REQ_ADDR_LSB +: 30] == a[`REQ_ADDR_LSB +: 30]) &&
            ((a[`REQ_BE_LSB +: 4] & b[`REQ_BE_LSB +: 4]) == 4'h0);
      end
   endfunction

   function [3:0] cmd_of;
      input [`REQ_W-1:0] a;
      begin
         if (a[`REQ_RD_BIT]) begin
            cmd_of = a[`REQ_IO_BIT] ? `LB_CMD_IO_RD : `LB_CMD_MEM_RD;
         end else begin
            cmd_of = a[`REQ_IO_BIT] ? `LB_CMD_IO_WR : `LB_CMD_MEM_WR;
         end
      end
   endfunction

   // ***************************************************************
   // Two-entry posting buffer
   // ***************************************************************
   reg [`REQ_W-1:0] buf_mem [0:(1 << BUF_AW)-1];
   reg [BUF_AW-1:0] wr_ptr;
   reg [BUF_AW-1:0] rd_ptr;
   reg [BUF_AW:0] cnt;
   wire [BUF_AW-1:0] rd_ptr_nx = rd_ptr + 1'b1;
   wire [`REQ_W-1:0] head = buf_mem[rd_ptr];
   wire [`REQ_W-1:0] second = buf_mem[rd_ptr_nx];
   wire push = req_valid && req_ready;
   wire pop;

   assign req_ready = (cnt != DEPTH);

   always @(posedge clk) begin
      if (push) begin
         buf_mem[wr_ptr] <= {req_read, req_io, req_prefetch, req_addr, req_be, req_data};
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= {BUF_AW{1'b0}};
         rd_ptr <= {BUF_AW{1'b0}};
         cnt <= {(BUF_AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr_nx;
         end
         if (push && !pop) begin
            cnt <= cnt + 1'b1;
         end else if (pop && !push) begin
            cnt <= cnt - 1'b1;
         end
      end
   end

   // ***************************************************************
   // Bus state shared by both engines
   // ***************************************************************
   reg [2:0] m_state;
   reg [1:0] t_state;
   reg idle_q;
   reg [`REQ_W-1:0] cur;
   reg more;
   reg [31:0] m_ad;
   reg m_ad_oe;
   reg [31:0] t_ad;
   reg t_ad_oe;

   wire xfer = !irdy_n_in && !trdy_n_in;
   wire bus_idle = frame_n_in && irdy_n_in;
   wire bus_free = bus_idle && (t_state == T_IDLE);

   assign pop = (m_state == M_IDLE && cnt != 0 && bus_free) ||
      (m_state == M_LOAD && cnt != 0 && can_merge(cur, head)) ||
      (m_state == M_DATA && xfer && more);

   assign ad_out = t_ad_oe ? t_ad : m_ad;
   assign ad_oe = m_ad_oe || t_ad_oe;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_q <= 1'b1;
      end else begin
         idle_q <= bus_idle;
      end
   end

   // ***************************************************************
   // Initiating engine
   // ***************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         m_state <= M_IDLE;
         cur <= {`REQ_W{1'b0}};
         more <= 1'b0;
         frame_n_out <= `LB_CTL_IDLE;
         frame_n_oe <= 1'b0;
         irdy_n_out <= `LB_CTL_IDLE;
         irdy_n_oe <= 1'b0;
         cbe_n_out <= `LB_CBE_IDLE;
         cbe_n_oe <= 1'b0;
         m_ad <= `LB_AD_RESET;
         m_ad_oe <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= `LB_AD_RESET;
      end else begin
         rsp_valid <= 1'b0;
         case (m_state)
            M_IDLE: begin
               if (cnt != 0 && bus_free) begin
                  cur <= head;
                  m_state <= M_LOAD;
               end
            end
            M_LOAD: begin
               if (cnt != 0 && can_merge(cur, head)) begin
                  // Disjoint bytes fold in; overlap opens a new transaction instead.
                  cur[`REQ_BE_LSB +: 4] <= cur[`REQ_BE_LSB +: 4] | head[`REQ_BE_LSB +: 4];
                  cur[`REQ_DATA_LSB +: 32] <= {
                     head[`REQ_BE_LSB+3] ? head[31:24] : cur[31:24],
                     head[`REQ_BE_LSB+2] ? head[23:16] : cur[23:16],
                     head[`REQ_BE_LSB+1] ? head[15:8] : cur[15:8],
                     head[`REQ_BE_LSB] ? head[7:0] : cur[7:0]};
               end else begin
                  frame_n_out <= 1'b0;
                  frame_n_oe <= 1'b1;
                  m_ad <= {cur[`REQ_ADDR_LSB +: 30], 2'b00};
                  m_ad_oe <= 1'b1;
                  cbe_n_out <= cmd_of(cur);
                  cbe_n_oe <= 1'b1;
                  m_state <= M_ADDR;
               end
            end
            M_ADDR: begin
               cbe_n_out <= ~cur[`REQ_BE_LSB +: 4];
               irdy_n_out <= 1'b0;
               irdy_n_oe <= 1'b1;
               if (cur[`REQ_RD_BIT]) begin
                  m_ad_oe <= 1'b0;
               end else begin
                  m_ad <= cur[`REQ_DATA_LSB +: 32];
               end
               more <= (cnt != 0) && can_combine(cur, head);
               // Ready is asserted on this same edge, so frame may drop with it.
               frame_n_out <= !((cnt != 0) && can_combine(cur, head));
               m_state <= M_DATA;
            end
            M_DATA: begin
               // Frame and ready stay frozen until the phase completes.
               if (xfer) begin
                  if (cur[`REQ_RD_BIT]) begin
                     rsp_valid <= 1'b1;
                     rsp_data <= ad_in;
                  end
                  if (more) begin
                     cur <= head;
                     cbe_n_out <= ~head[`REQ_BE_LSB +: 4];
                     m_ad <= head[`REQ_DATA_LSB +: 32];
                     more <= (cnt > 1) && can_combine(head, second);
                     frame_n_out <= !((cnt > 1) && can_combine(head, second));
                  end else begin
                     irdy_n_out <= `LB_CTL_IDLE;
                     cbe_n_out <= `LB_CBE_IDLE;
                     m_ad_oe <= 1'b0;
                     m_state <= M_END;
                  end
               end
            end
            M_END: begin
               frame_n_oe <= 1'b0;
               irdy_n_oe <= 1'b0;
               cbe_n_oe <= 1'b0;
               m_state <= M_IDLE;
            end
            default: begin
               m_state <= M_IDLE;
            end
         endcase
      end
   end

   // ***************************************************************
   // Claiming memory target
   // ***************************************************************
   reg [31:0] tgt_mem [0:(1 << TGT_AW)-1];
   reg [TGT_AW-1:0] t_idx;
   reg t_rd;
   wire [TGT_AW-1:0] a_idx = ad_in[TGT_AW+1:2];
   wire [TGT_AW-1:0] t_idx_nx = t_idx + 1'b1;
   wire addr_phase = (t_state == T_IDLE) && idle_q && !frame_n_in;
   wire hit = (ad_in[31:TGT_AW+2] == TGT_BASE[31:TGT_AW+2]) &&
      ((cbe_n_in == `LB_CMD_MEM_RD) || (cbe_n_in == `LB_CMD_MEM_WR));
   wire claim = addr_phase && hit && (m_state == M_IDLE);
   wire [3:0] wbe = ~cbe_n_in;

   always @(posedge clk) begin
      if (t_state == T_DATA && !t_rd && xfer) begin
         tgt_mem[t_idx] <= {wbe[3] ? ad_in[31:24] : tgt_mem[t_idx][31:24],
            wbe[2] ? ad_in[23:16] : tgt_mem[t_idx][23:16],
            wbe[1] ? ad_in[15:8] : tgt_mem[t_idx][15:8],
            wbe[0] ? ad_in[7:0] : tgt_mem[t_idx][7:0]};
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         t_state <= T_IDLE;
         t_idx <= {TGT_AW{1'b0}};
         t_rd <= 1'b0;
         t_ad <= `LB_AD_RESET;
         t_ad_oe <= 1'b0;
         devsel_n_out <= `LB_CTL_IDLE;
         devsel_n_oe <= 1'b0;
         trdy_n_out <= `LB_CTL_IDLE;
         trdy_n_oe <= 1'b0;
      end else begin
         case (t_state)
            T_IDLE: begin
               devsel_n_oe <= 1'b0;
               trdy_n_oe <= 1'b0;
               if (claim) begin
                  t_idx <= a_idx;
                  t_rd <= (cbe_n_in == `LB_CMD_MEM_RD);
                  t_ad <= tgt_mem[a_idx];
                  devsel_n_out <= 1'b0;
                  devsel_n_oe <= 1'b1;
                  trdy_n_oe <= 1'b1;
                  if (cbe_n_in == `LB_CMD_MEM_RD) begin
                     trdy_n_out <= `LB_CTL_IDLE;
                     t_state <= T_TURN;
                  end else begin
                     trdy_n_out <= 1'b0;
                     t_state <= T_DATA;
                  end
               end
            end
            T_TURN: begin
               t_ad_oe <= 1'b1;
               trdy_n_out <= 1'b0;
               t_state <= T_DATA;
            end
            T_DATA: begin
               if (xfer) begin
                  t_idx <= t_idx_nx;
                  t_ad <= tgt_mem[t_idx_nx];
                  if (frame_n_in) begin
                     // Final phase done; drive controls high once before release.
                     devsel_n_out <= `LB_CTL_IDLE;
                     trdy_n_out <= `LB_CTL_IDLE;
                     t_ad_oe <= 1'b0;
                     t_state <= T_END;
                  end
               end
            end
            T_END: begin
               devsel_n_oe <= 1'b0;
               trdy_n_oe <= 1'b0;
               t_state <= T_IDLE;
            end
            default: begin
               t_state <= T_IDLE;
            end
         endcase
      end
   end

endmodule

// >>> lbus_map.vh
// Command codes, request word layout and idle drive levels for the local bus bridge.
`ifndef LBUS_MAP_VH
`define LBUS_MAP_VH

// ***************************************************************
// Bus commands carried on the command/byte-enable lines
// ***************************************************************
`define LB_CMD_IO_RD 4'h2
`define LB_CMD_IO_WR 4'h3
`define LB_CMD_MEM_RD 4'h6
`define LB_CMD_MEM_WR 4'h7

// ***************************************************************
// Request word layout inside the posting buffer
// ***************************************************************
`define REQ_DATA_LSB 0
`define REQ_BE_LSB 32
`define REQ_ADDR_LSB 36
`define REQ_PF_BIT 66
`define REQ_IO_BIT 67
`define REQ_RD_BIT 68
`define REQ_W 69

// ***************************************************************
// Reset and idle values
// ***************************************************************
`define LB_CTL_IDLE 1'b1
`define LB_CBE_IDLE 4'hf
`define LB_AD_RESET 32'h0000_0000

`endif

// >>> lbus_bridge_asserts.sv
// Port checks for the local bus bridge.
`timescale 1ns/1ps
module lbus_bridge_asserts (
   input wire clk,
   input wire rst_n,
   input wire rsp_valid,
   input wire [31:0] rsp_data,
   input wire frame_n_in,
   input wire frame_n_out,
   input wire frame_n_oe,
   input wire irdy_n_in,
   input wire irdy_n_out,
   input wire irdy_n_oe,
   input wire trdy_n_in,
   input wire trdy_n_out,
   input wire trdy_n_oe,
   input wire devsel_n_out,
   input wire devsel_n_oe,
   input wire [31:0] ad_in,
   input wire [31:0] ad_out,
   input wire ad_oe,
   input wire [3:0] cbe_n_out,
   input wire cbe_n_oe
);
   // *****
   // Completion tracking
   // *****
   reg rd_done;
   reg [31:0] rd_word;
   wire xfer = !irdy_n_in && !trdy_n_in && irdy_n_oe && !irdy_n_out;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_done <= 1'b0;
         rd_word <= 32'h0;
      end else begin
         rd_done <= xfer && !ad_oe;
         if (xfer) rd_word <= ad_in;
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_addr_cmd: assert property (
      $fell(frame_n_out) && frame_n_oe |-> ad_oe && cbe_n_oe && cbe_n_out[1] && !cbe_n_out[3])
      else $error("address phase lacks address or command");
   a_rd_turn: assert property (
      $fell(frame_n_out) && frame_n_oe && !cbe_n_out[0] |=> !ad_oe)
      else $error("read without turnaround");
   a_frame_irdy: assert property (
      frame_n_oe && $rose(frame_n_out) |-> irdy_n_oe && !irdy_n_out)
      else $error("frame released without initiator ready");
   a_be_drive: assert property (irdy_n_oe |-> cbe_n_oe)
      else $error("byte enables floating in data phase");
   a_be_next: assert property (
      xfer && !frame_n_in |=> cbe_n_oe && !irdy_n_out)
      else $error("next phase not presented after completion");
   a_wait_hold: assert property (
      irdy_n_oe && !irdy_n_out && trdy_n_in |=> $stable(cbe_n_out) && $stable(frame_n_out)
      && (!ad_oe || $stable(ad_out)))
      else $error("master changed phase during wait");
   a_trdy_devsel: assert property (
      trdy_n_oe && !trdy_n_out |-> devsel_n_oe && !devsel_n_out)
      else $error("target ready without select");
   a_tgt_ad_on: assert property (
      devsel_n_oe && !devsel_n_out && !trdy_n_out && ad_oe |=> ad_oe || devsel_n_out)
      else $error("target data drivers dropped early");
   a_idle_after: assert property (
      xfer && frame_n_in |=> irdy_n_out && !ad_oe ##1 !irdy_n_oe && !frame_n_oe)
      else $error("master did not return bus to idle");
   a_rsp_done: assert property (rd_done |-> ##[0:1] rsp_valid)
      else $error("read answer missing");
   a_rsp_data: assert property (rsp_valid |-> rsp_data == rd_word && rd_done)
      else $error("read answer does not match bus word");
   c_wait: cover property (!irdy_n_in && trdy_n_in);
   c_target: cover property (trdy_n_oe && !trdy_n_out);
   c_read: cover property (rsp_valid);
endmodule

bind lbus_bridge lbus_bridge_asserts chk (.*);

// >>> lbus_far_agent.sv
// Far-side agent: memory and I/O target with wait states plus a single-phase master.
`timescale 1ns/1ps
module lbus_far_agent (
   input wire clk,
   input wire [1:0] slow,
   input wire frame_n,
   input wire irdy_n,
   input wire trdy_n,
   input wire [31:0] ad,
   input wire [3:0] cbe_n,
   output reg fr_o,
   output reg fr_oe,
   output reg ir_o,
   output reg ir_oe,
   output reg tr_o,
   output reg tr_oe,
   output reg dv_o,
   output reg dv_oe,
   output reg [31:0] ad_o,
   output reg ad_oe,
   output reg [3:0] cb_o,
   output reg cb_oe
);
   // *****
   // Target side
   // *****
   reg [31:0] mem [0:255];
   reg [31:0] wd [0:63];
   reg [3:0] wb [0:63];
   reg [31:0] a, cap;
   reg rd, last, idle;
   integer wn, tn, i;
   initial begin
      {fr_oe, ir_oe, tr_oe, dv_oe, ad_oe, cb_oe} = 6'h00;
      {fr_o, ir_o, tr_o, dv_o, cb_o} = 8'hff;
      ad_o = 32'h0;
      wn = 0;
      tn = 0;
      idle = 1;
      forever begin
         @(posedge clk);
         if (idle && !frame_n && ad[31:28] == 4'h8 && cbe_n[1] && !cbe_n[3]) begin
            a = ad;
            rd = !cbe_n[0];
            tn = tn + 1;
            last = 0;
            #1 dv_oe = 1;
            dv_o = 0;
            tr_oe = 1;
            if (rd) begin
               @(posedge clk);
               #1 ad_oe = 1;
            end
            while (!last) begin
               #1 ad_o = mem[a[9:2]];
               if (slow != 0) begin
                  tr_o = 1;
                  repeat (slow) @(posedge clk);
                  #1;
               end
               tr_o = 0;
               @(posedge clk);
               while (irdy_n) @(posedge clk);
               last = frame_n;
               if (!rd) begin
                  for (i = 0; i < 4; i++) if (!cbe_n[i]) mem[a[9:2]][i*8 +: 8] = ad[i*8 +: 8];
                  wd[wn] = ad;
                  wb[wn] = cbe_n;
                  wn = wn + 1;
               end
               a = a + 4;
            end
            #1 {dv_o, tr_o, ad_oe} = 3'b110;
            @(posedge clk);
            #1 {dv_oe, tr_oe} = 2'b00;
         end
         idle = frame_n && irdy_n;
      end
   end
   // *****
   // Master side
   // *****
   task m_go(input [31:0] adr, input [3:0] cmd);
      begin
         @(posedge clk);
         #1 {fr_oe, ad_oe, cb_oe, ir_oe, fr_o} = 5'b11110;
         ad_o = adr;
         cb_o = cmd;
         @(posedge clk);
         #1 {fr_o, ir_o} = 2'b10;
      end
   endtask
   task m_wait;
      begin
         @(posedge clk);
         while (trdy_n) @(posedge clk);
         cap = ad;
         #1 {ir_o, ad_oe} = 2'b10;
         cb_o = 4'hf;
         @(posedge clk);
         #1 {fr_oe, ir_oe, cb_oe} = 3'h0;
      end
   endtask
   task mwr(input [31:0] adr, input [31:0] d, input [3:0] be);
      begin
         m_go(adr, 4'h7);
         ad_o = d;
         cb_o = ~be;
         m_wait;
      end
   endtask
   task mrd(input [31:0] adr, output [31:0] d);
      begin
         m_go(adr, 4'h6);
         ad_oe = 0;
         cb_o = 4'h0;
         m_wait;
         d = cap;
      end
   endtask
endmodule

// >>> lbus_bridge_tb_top.sv
// Self-checking testbench for the local bus bridge.
`timescale 1ns/1ps
module lbus_bridge_tb_top;
   // *****
   // Clock, reset and bus wiring
   // *****
   reg clk, rst_n, req_valid, req_read, req_io, req_prefetch, seen_full, cyc;
   reg [29:0] req_addr;
   reg [3:0] req_be;
   reg [31:0] req_data;
   reg [1:0] slow;
   integer mismatches, n_compared, t0, w0;
   wire req_ready, rsp_valid, fr_o, fr_oe, ir_o, ir_oe, tr_o, tr_oe, dv_o, dv_oe, p_ad_oe, cb_oe;
   wire d_fr, d_fr_oe, d_ir, d_ir_oe, d_tr, d_tr_oe, d_dv, d_dv_oe, ad_oe, cbe_n_oe;
   wire frame_n, irdy_n, trdy_n, devsel_n;
   wire [31:0] rsp_data, ad_out, p_ad, ad;
   wire [3:0] cbe_n_out, cb_o, cbe_n;
   wire [31:0] flt = {32{cyc}} ^ 32'h5a5a_c3c3;
   assign frame_n = d_fr_oe ? d_fr : fr_oe ? fr_o : 1'b1;
   assign irdy_n = d_ir_oe ? d_ir : ir_oe ? ir_o : 1'b1;
   assign trdy_n = d_tr_oe ? d_tr : tr_oe ? tr_o : 1'b1;
   assign devsel_n = d_dv_oe ? d_dv : dv_oe ? dv_o : 1'b1;
   assign ad = ad_oe ? ad_out : p_ad_oe ? p_ad : flt;
   assign cbe_n = cbe_n_oe ? cbe_n_out : cb_oe ? cb_o : flt[3:0];
   lbus_bridge #(.TGT_AW(4), .TGT_BASE(32'h0001_0000), .BUF_AW(1)) dut (
      .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req_read(req_read), .req_io(req_io), .req_prefetch(req_prefetch),
      .req_addr(req_addr), .req_be(req_be), .req_data(req_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .frame_n_in(frame_n), .frame_n_out(d_fr), .frame_n_oe(d_fr_oe),
      .irdy_n_in(irdy_n), .irdy_n_out(d_ir), .irdy_n_oe(d_ir_oe),
      .trdy_n_in(trdy_n), .trdy_n_out(d_tr), .trdy_n_oe(d_tr_oe),
      .devsel_n_in(devsel_n), .devsel_n_out(d_dv), .devsel_n_oe(d_dv_oe),
      .ad_in(ad), .ad_out(ad_out), .ad_oe(ad_oe),
      .cbe_n_in(cbe_n), .cbe_n_out(cbe_n_out), .cbe_n_oe(cbe_n_oe));
   lbus_far_agent far (
      .clk(clk), .slow(slow), .frame_n(frame_n), .irdy_n(irdy_n), .trdy_n(trdy_n),
      .ad(ad), .cbe_n(cbe_n), .fr_o(fr_o), .fr_oe(fr_oe), .ir_o(ir_o), .ir_oe(ir_oe),
      .tr_o(tr_o), .tr_oe(tr_oe), .dv_o(dv_o), .dv_oe(dv_oe), .ad_o(p_ad),
      .ad_oe(p_ad_oe), .cb_o(cb_o), .cb_oe(cb_oe));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc <= !cyc;
   // *****
   // Shared tasks
   // *****
   task stop_test;
      begin
         if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task cmp(input string name, input [31:0] exp, input [31:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task put(input rd, input io, input pf, input [31:0] ba, input [3:0] be, input [31:0] d);
      reg r;
      begin
         #1 {req_valid, req_read, req_io, req_prefetch} = {1'b1, rd, io, pf};
         {req_addr, req_be, req_data} = {ba[31:2], be, d};
         do begin
            r = (req_ready === 1'b1);
            seen_full = seen_full | !r;
            @(posedge clk);
            if (!r) #1;
         end while (!r);
      end
   endtask
   task rel;
      #1 req_valid = 0;
   endtask
   task settle;
      integer q, k;
      begin
         q = 0;
         k = 0;
         while (q < 6 && k < 1000) begin
            @(posedge clk);
            k = k + 1;
            q = (frame_n && irdy_n && req_ready) ? q + 1 : 0;
         end
         cmp("settle", 6, q);
      end
   endtask
   task get(input [31:0] exp);
      integer k;
      begin
         k = 0;
         @(posedge clk);
         #1;
         while (rsp_valid !== 1'b1 && k < 300) begin
            @(posedge clk);
            #1;
            k = k + 1;
         end
         cmp("rsp_valid", 1, rsp_valid);
         cmp("rsp_data", exp, rsp_data);
      end
   endtask
   task log(input integer i, input [31:0] d, input [3:0] be);
      begin
         cmp("data", d, far.wd[i]);
         cmp("be_n", {28'h0, ~be}, {28'h0, far.wb[i]});
      end
   endtask
   // *****
   // Scenarios
   // *****
   task t_collapse;
      begin
         t0 = far.tn;
         w0 = far.wn;
         put(0, 0, 1, 32'h8000_0100, 4'hf, 32'h1111_1111);
         put(0, 0, 1, 32'h8000_0100, 4'h8, 32'h2222_2222);
         put(0, 0, 1, 32'h8000_0104, 4'hf, 32'h3333_3333);
         put(0, 0, 1, 32'h8000_0108, 4'hf, 32'h4444_4444);
         rel;
         settle;
         cmp("phases", 4, far.wn - w0);
         cmp("split", 1, far.tn - t0 >= 2);
         log(w0, 32'h1111_1111, 4'hf);
         log(w0 + 1, 32'h2222_2222, 4'h8);
         log(w0 + 2, 32'h3333_3333, 4'hf);
         log(w0 + 3, 32'h4444_4444, 4'hf);
      end
   endtask
   task t_merge;
      begin
         t0 = far.tn;
         put(0, 1, 1, 32'h8000_0200, 4'h1, 32'h0000_00aa);
         put(0, 1, 1, 32'h8000_0200, 4'h2, 32'h0000_bb00);
         put(0, 0, 0, 32'h8000_0208, 4'h1, 32'h0000_00aa);
         put(0, 0, 0, 32'h8000_0208, 4'h2, 32'h0000_bb00);
         rel;
         settle;
         cmp("unmerged", 4, far.tn - t0);
         t0 = far.tn;
         put(0, 0, 1, 32'h8000_0204, 4'h1, 32'h0000_00aa);
         put(0, 0, 1, 32'h8000_0204, 4'h2, 32'h0000_bb00);
         rel;
         settle;
         cmp("merged", 32'hbbaa, {16'h0, far.mem[8'h81][15:0]});
         cmp("one_txn", 1, far.tn - t0);
         log(far.wn - 1, 32'h0000_bbaa, 4'h3);
      end
   endtask
   task t_read;
      begin
         put(1, 0, 1, 32'h8000_0104, 4'hf, 32'h0);
         put(1, 1, 0, 32'h8000_0108, 4'hf, 32'h0);
         put(1, 0, 1, 32'h8000_0100, 4'hf, 32'h0);
         rel;
         get(32'h3333_3333);
         get(32'h4444_4444);
         get(32'h2211_1111);
      end
   endtask
   task t_slow;
      integer i;
      begin
         slow = 2;
         seen_full = 0;
         w0 = far.wn;
         for (i = 0; i < 6; i++) put(0, 0, 1, 32'h8000_0300 + 4 * i, 4'hf, 32'hc0de_0000 + i);
         put(1, 0, 1, 32'h8000_0314, 4'hf, 32'h0);
         rel;
         get(32'hc0de_0005);
         cmp("full", 1, seen_full);
         settle;
         cmp("drained", 1, req_ready);
         cmp("phases", 6, far.wn - w0);
         slow = 0;
      end
   endtask
   task t_target;
      reg [31:0] d;
      begin
         far.mwr(32'h0001_003c, 32'hdead_beef, 4'hf);
         far.mwr(32'h0001_003c, 32'h0000_5500, 4'h2);
         far.mrd(32'h0001_003c, d);
         cmp("tgt_rd", 32'hdead_55ef, d);
      end
   endtask
   initial begin
      {rst_n, req_valid, req_read, req_io, req_prefetch, seen_full, cyc} = 7'h0;
      {req_addr, req_be, req_data} = 66'h0;
      slow = 0;
      mismatches = 0;
      n_compared = 0;
      repeat (20) @(posedge clk);
      #1 rst_n = 1;
      t_collapse;
      t_merge;
      t_read;
      t_slow;
      t_target;
      stop_test;
   end
   initial begin
      #500000;
      mismatches = mismatches + 1;
      stop_test;
   end
endmodule
